// [rtl/blr_map.vh]
// Register map, field positions, reset values and counts of the break, low-power and reset-status block.
`ifndef BLR_MAP_VH
`define BLR_MAP_VH

// Register indices as printed; the byte address is four times the index.
`define BLR_IDX_BREAK_STATUS     18'h0_FE00
`define BLR_IDX_RESET_SOURCE     18'h0_FE01
`define BLR_IDX_BREAK_FLAG_CTRL  18'h0_FE03
`define BLR_ADDR_BREAK_STATUS    18'h3_F800
`define BLR_ADDR_RESET_SOURCE    18'h3_F804
`define BLR_ADDR_BREAK_FLAG_CTRL 18'h3_F80C
`define BLR_ADDR_W               18

// Break status field.
`define BLR_BIT_BREAK_WAIT_EXIT  1

// Reset source status fields.
`define BLR_BIT_POWER_ON         7
`define BLR_BIT_PIN              6
`define BLR_BIT_WATCHDOG         5
`define BLR_BIT_BAD_OPCODE       4
`define BLR_BIT_BAD_ADDRESS      3
`define BLR_BIT_MONITOR_ENTRY    2
`define BLR_BIT_LOW_VOLTAGE      1

// Break flag control field.
`define BLR_BIT_BREAK_CLEAR_EN   7

// Reset values.
`define BLR_RST_BREAK_STATUS     8'h00
`define BLR_RST_RESET_SOURCE     8'h80
`define BLR_RST_BREAK_FLAG_CTRL  8'h00

// Erased vector byte that selects monitor entry.
`define BLR_ERASED_BYTE          8'hFF

// Stop recovery lengths in reference clock cycles.
`define BLR_STOP_REC_LONG        13'h1000
`define BLR_STOP_REC_SHORT       13'h0020
`define BLR_CNT_W                13

`endif

// [rtl/blr_recovery_counter.v]
// Stop recovery counter that is held clear during stop and then times the recovery period.
`timescale 1ns/1ps
module blr_recovery_counter (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        holdClear,
	input  wire        run,
	input  wire        shortRecovery,
	output reg         done
);
`include "blr_map.vh"

	reg  [`BLR_CNT_W-1:0] count;
	wire [`BLR_CNT_W-1:0] target;
	wire [`BLR_CNT_W-1:0] next_count;

	// The recovery length follows the short stop recovery option.
	assign target = shortRecovery ? `BLR_STOP_REC_SHORT : `BLR_STOP_REC_LONG;
	assign next_count = count + 13'h0001;

	// Counter stays at zero while held; done pulses on the last recovery cycle.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= 13'h0000;
			done  <= 1'b0;
		end else if (holdClear) begin
			count <= 13'h0000;
			done  <= 1'b0;
		end else if (run && !done) begin
			count <= next_count;
			done  <= (next_count == target);
		end else begin
			done  <= 1'b0;
		end
	end

endmodule

// [rtl/blr_top.v]
// Reset status, break control and wait/stop sequencing with an APB register slave.
// Function
// - All reset sources share equal top priority.
// - Break interrupt forces CPU to software vector.
// - Break without clear enable protects status flags; here only the reset-source flags, a zero write still clears break-wait-exit.
// - Flags cleared in enabled break stay cleared.
// - Two-step flag clears stay protected during break.
// - Wait or stop clears the interrupt mask.
// - Wait gates CPU clocks, peripherals keep running.
// - Wait wake stacking starts one cycle later.
// - Reset or break exits wait; break sets flag.
// - Watchdog runs in wait unless disabled.
// - Stop resets counter and disables both clocks.
// - Stop exits by interrupt after recovery, or by reset at once.
// - Recovery lasts 4096 cycles, or 32 short.
// - Counter held in stop, then times recovery.
// - Break-wait-exit flag cleared by zero write, reset.
// - Reading reset-source status clears all flags.
// - Power-on sets its flag, clears others.
// - Each reset cause has its own flag.
// - Monitor flag set on erased vectors, high IRQ.
// - Break clearing allowed only with enable set; here the break-wait-exit flag still clears on a zero write.
// - Break status flag sits at bit one.
// - Three registers at their fixed addresses.
`timescale 1ns/1ps
module blr_top (
	input  wire        clk,
	input  wire        arst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [17:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	input  wire        porEvent,
	input  wire        pinReset_n,
	input  wire        watchdogTimeout,
	input  wire        badOpcode,
	input  wire        badAddress,
	input  wire        lowVoltage,
	input  wire        monitorCheck,
	input  wire [7:0]  resetVectorHi,
	input  wire [7:0]  resetVectorLo,
	input  wire        irqPin,
	output reg         systemReset,
	input  wire        breakIrq,
	input  wire        breakReturn,
	output reg         forceSwiVector,
	output reg         breakState,
	output wire        flagClearAllow,
	input  wire        lowPowerReq,
	input  wire        lowPowerStop,
	input  wire        wakeIrq,
	input  wire        shortStopRecovery,
	input  wire        watchdogDisable,
	output reg         clearIntMask,
	output reg         stackStart,
	output wire        cpuClockEn,
	output wire        busClockEn,
	output wire        refClockEn,
	output wire        watchdogRun,
	output wire [4:0]  powerState
);
`include "blr_map.vh"

	// One-hot sequencer states; exactly one bit is set in every legal state.
	localparam [4:0] ST_RUN     = 5'h01;
	localparam [4:0] ST_WAIT    = 5'h02;
	localparam [4:0] ST_STOP    = 5'h04;
	localparam [4:0] ST_RECOVER = 5'h08;
	localparam [4:0] ST_STACK   = 5'h10;

	// Synchroniser stages, break tracking, register contents and sequencer state.
	reg        pinMeta;
	reg        pinSync;
	reg        irqMeta;
	reg        irqSync;
	reg        breakIrqLast;
	reg        breakWaitExit;
	reg        breakClearEnable;
	reg  [7:0] resetSource;
	reg  [7:0] next_resetSource;
	reg  [4:0] state;
	reg  [4:0] next_state;
	reg        next_stackStart;
	reg        setBreakWaitExit;
	reg  [7:0] readByte;
	wire       pinEvent;
	wire       monitorEvent;
	wire       anyReset;
	wire       breakRise;
	wire       apbAccess;
	wire       apbWrite;
	wire       apbRead;
	wire       selBreakStatus;
	wire       selResetSource;
	wire       selFlagCtrl;
	wire       mapped;
	wire       recoveryDone;

	// Two flip-flops bring the reset pin and the IRQ pin into the clock domain.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pinMeta <= 1'b1;
			pinSync <= 1'b1;
			irqMeta <= 1'b0;
			irqSync <= 1'b0;
		end else begin
			pinMeta <= pinReset_n;
			pinSync <= pinMeta;
			irqMeta <= irqPin;
			irqSync <= irqMeta;
		end
	end

	// Cause decoding; the pin counts while it is held low after synchronising.
	assign pinEvent = !pinSync;
	assign monitorEvent = monitorCheck && irqSync &&
		(resetVectorHi == `BLR_ERASED_BYTE) && (resetVectorLo == `BLR_ERASED_BYTE);

	// Every source is simply ORed, so no source can block another.
	assign anyReset = porEvent | pinEvent | watchdogTimeout | badOpcode |
		badAddress | lowVoltage | monitorEvent;

	// The reset request leaves through a register so the output is glitch free.
	// A source that is still active keeps the request high for as long as it lasts.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			systemReset <= 1'b1;
		end else begin
			systemReset <= anyReset;
		end
	end

	// APB decode; the slave answers every access in its first access cycle.
	// Writes to unmapped or read-only locations are answered but change nothing.
	assign pready = 1'b1;
	assign apbAccess = psel && penable;
	assign apbWrite = apbAccess && pwrite;
	assign apbRead = apbAccess && !pwrite;
	assign selBreakStatus = (paddr == `BLR_ADDR_BREAK_STATUS);
	assign selResetSource = (paddr == `BLR_ADDR_RESET_SOURCE);
	assign selFlagCtrl = (paddr == `BLR_ADDR_BREAK_FLAG_CTRL);
	assign mapped = selBreakStatus | selResetSource | selFlagCtrl;

	// Status clearing is allowed outside break, or in break with the enable set.
	assign flagClearAllow = !breakState || breakClearEnable;

	// Read data are chosen here and captured at the setup edge; the error answer is combinational.
	// The reset source byte is taken from its next value, which is what stands in the access cycle.
	always @* begin
		readByte = 8'h00;
		pslverr = 1'b0;
		if (psel && !mapped) begin
			pslverr = 1'b1;
		end
		if (selBreakStatus) begin
			readByte[`BLR_BIT_BREAK_WAIT_EXIT] = breakWaitExit;
		end else if (selResetSource) begin
			readByte = next_resetSource;
		end else if (selFlagCtrl) begin
			readByte[`BLR_BIT_BREAK_CLEAR_EN] = breakClearEnable;
		end
	end

	// Registered read data hold steady for the whole access phase.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= {24'h00_0000, readByte};
		end
	end

	// Break flag control register; software sets or clears the enable at will.
	// The enable resets to zero, so flags are protected in break until software opts in.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			breakClearEnable <= 1'b0;
		end else if (apbWrite && selFlagCtrl) begin
			breakClearEnable <= pwdata[`BLR_BIT_BREAK_CLEAR_EN];
		end
	end

	// Break entry on a rising break interrupt; the CPU ends it with its return pulse.
	assign breakRise = breakIrq && !breakIrqLast;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			breakIrqLast   <= 1'b0;
			breakState     <= 1'b0;
			forceSwiVector <= 1'b0;
		end else begin
			breakIrqLast   <= breakIrq;
			forceSwiVector <= breakRise;
			if (anyReset) begin
				breakState <= 1'b0;
			end else if (breakRise) begin
				breakState <= 1'b1;
			end else if (breakReturn) begin
				breakState <= 1'b0;
			end
		end
	end

	// Reset source flags: power-on replaces all, other causes add their bit.
	// A read clears the flags unless break protection holds them; a cause wins over the read.
	always @* begin
		next_resetSource = resetSource;
		if (apbRead && selResetSource && flagClearAllow) begin
			next_resetSource = 8'h00;
		end
		if (pinEvent) begin
			next_resetSource[`BLR_BIT_PIN] = 1'b1;
		end
		if (watchdogTimeout) begin
			next_resetSource[`BLR_BIT_WATCHDOG] = 1'b1;
		end
		if (badOpcode) begin
			next_resetSource[`BLR_BIT_BAD_OPCODE] = 1'b1;
		end
		if (badAddress) begin
			next_resetSource[`BLR_BIT_BAD_ADDRESS] = 1'b1;
		end
		if (monitorEvent) begin
			next_resetSource[`BLR_BIT_MONITOR_ENTRY] = 1'b1;
		end
		if (lowVoltage) begin
			next_resetSource[`BLR_BIT_LOW_VOLTAGE] = 1'b1;
		end
		if (porEvent) begin
			next_resetSource = `BLR_RST_RESET_SOURCE;
		end
	end

	// The reset source register itself; arst_n stands for the power-on reset.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			resetSource <= `BLR_RST_RESET_SOURCE;
		end else begin
			resetSource <= next_resetSource;
		end
	end

	// Break status flag: set by break leaving wait, cleared by a zero write or any reset.
	// Software writes of a one leave the flag as it is.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			breakWaitExit <= 1'b0;
		end else if (anyReset) begin
			breakWaitExit <= 1'b0;
		end else if (setBreakWaitExit) begin
			breakWaitExit <= 1'b1;
		end else if (apbWrite && selBreakStatus && !pwdata[`BLR_BIT_BREAK_WAIT_EXIT]) begin
			breakWaitExit <= 1'b0;
		end
	end

	// Low-power sequencer; a request is a single pulse that picks wait or stop.
	// Any reset source ends wait, stop and recovery, since reset outranks every wake.
	always @* begin
		next_state = state;
		next_stackStart = 1'b0;
		setBreakWaitExit = 1'b0;
		case (state)
			ST_RUN: begin
				if (lowPowerReq && !anyReset) begin
					next_state = lowPowerStop ? ST_STOP : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (anyReset) begin
					next_state = ST_RUN;
				end else if (breakRise) begin
					setBreakWaitExit = 1'b1;
					next_state = ST_RUN;
				end else if (wakeIrq) begin
					next_state = ST_STACK;
				end
			end
			ST_STOP: begin
				if (anyReset) begin
					next_state = ST_RUN;
				end else if (wakeIrq) begin
					next_state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (anyReset) begin
					next_state = ST_RUN;
				end else if (recoveryDone) begin
					next_state = ST_STACK;
				end
			end
			ST_STACK: begin
				next_stackStart = 1'b1;
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// State register plus the one-cycle pulses toward the CPU.
	// The interrupt mask clear follows an accepted request in both modes.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state        <= ST_RUN;
			stackStart   <= 1'b0;
			clearIntMask <= 1'b0;
		end else begin
			state        <= next_state;
			stackStart   <= next_stackStart;
			clearIntMask <= (state == ST_RUN) && lowPowerReq && !anyReset;
		end
	end

	// Clock gating: wait stops only the CPU, stop and recovery stop both generator outputs.
	// The watchdog runs in wait unless the option disables it; stop halts it with its clock.
	assign cpuClockEn = (state == ST_RUN) || (state == ST_STACK);
	assign busClockEn = !((state == ST_STOP) || (state == ST_RECOVER));
	assign refClockEn = busClockEn;
	assign watchdogRun = !watchdogDisable && busClockEn;
	assign powerState = state;

	// The counter is cleared from stop entry until recovery and then times it.
	// Recovery counts reference clock cycles, which in this block are the main clock.
	blr_recovery_counter u_recovery (
		.clk           (clk),
		.arst_n        (arst_n),
		.holdClear     (state != ST_RECOVER),
		.run           (state == ST_RECOVER),
		.shortRecovery (shortStopRecovery),
		.done          (recoveryDone)
	);

	// Peripherals that use a two-step clear sample flagClearAllow at their second step.
	// A first step taken before break therefore cannot finish the clear while break holds.
	// Once break ends the allow line rises again and the second step clears as usual.

endmodule

// [verif/blr_cpu_model.sv]
// Behavioural CPU issuing wait, stop and break-return pulses.
`timescale 1ns/1ps
module blr_cpu_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] cmd,
	output logic            lowPowerReq,
	output logic            lowPowerStop,
	output logic            breakReturn
);
	// Codes 1 and 2 ask for wait and stop, 3 leaves break; the mode line wanders when idle.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lowPowerReq <= 1'b0;
			lowPowerStop <= 1'b0;
			breakReturn <= 1'b0;
		end else begin
			lowPowerReq <= cmd == 2'h1 || cmd == 2'h2;
			lowPowerStop <= cmd == 2'h0 ? ~lowPowerStop : cmd == 2'h2;
			breakReturn <= cmd == 2'h3;
		end
	end
endmodule

// [verif/blr_top_asserts.sv]
// Port-level checks of the low-power, break and register behaviour.
`timescale 1ns/1ps
`include "blr_map.vh"
module blr_top_asserts (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic [17:0] paddr,
	input wire logic        pslverr,
	input wire logic        breakIrq,
	input wire logic        breakState,
	input wire logic        forceSwiVector,
	input wire logic        lowPowerReq,
	input wire logic        systemReset,
	input wire logic        wakeIrq,
	input wire logic        shortStopRecovery,
	input wire logic        clearIntMask,
	input wire logic        stackStart,
	input wire logic        cpuClockEn,
	input wire logic        busClockEn,
	input wire logic        refClockEn,
	input wire logic [4:0]  powerState
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// State decode and address map.
	wire logic inRun = powerState == 5'h01;
	wire logic inWait = powerState == 5'h02;
	wire logic inStop = powerState == 5'h04;
	wire logic hit = paddr == `BLR_ADDR_BREAK_STATUS || paddr == `BLR_ADDR_RESET_SOURCE
		|| paddr == `BLR_ADDR_BREAK_FLAG_CTRL;
	// A wake passes one stacking cycle before the stack pulse.
	sequence s_stack;
		powerState == 5'h10 ##1 stackStart;
	endsequence
	// Short stop recovery keeps the stack pulse away for about 32 cycles and then lets it through.
	sequence s_recover;
		!stackStart [*8] ##[23:28] stackStart;
	endsequence
	a_mask_clear: assert property (lowPowerReq && inRun && !systemReset |=> clearIntMask)
		else $error("mask not cleared");
	a_wait_clocks: assert property (inWait |-> !cpuClockEn && busClockEn && refClockEn)
		else $error("wait clocks wrong");
	a_wait_wake: assert property (inWait && wakeIrq && !breakIrq && !systemReset |=> s_stack)
		else $error("wait wake late");
	a_break_exit: assert property (inWait && $rose(breakIrq) |=> inRun && breakState)
		else $error("break did not end wait");
	a_stop_clocks: assert property (inStop |-> !cpuClockEn && !busClockEn && !refClockEn)
		else $error("stop clocks running");
	a_stop_delay: assert property (inStop && wakeIrq && shortStopRecovery && !systemReset |=> s_recover)
		else $error("stop recovery length");
	a_break_force: assert property ($rose(breakIrq) && !breakState |=> forceSwiVector && breakState)
		else $error("break not forced");
	a_unmapped_err: assert property (psel && !hit |-> pslverr)
		else $error("no error on unmapped");
endmodule

// [verif/blr_top_test.sv]
// Self-checking bench of the break, low-power and reset-status block.
`timescale 1ns/1ps
`include "blr_map.vh"
module blr_top_test;
	localparam logic [17:0] BS = `BLR_ADDR_BREAK_STATUS;
	localparam logic [17:0] RS = `BLR_ADDR_RESET_SOURCE;
	localparam logic [17:0] BF = `BLR_ADDR_BREAK_FLAG_CTRL;
	logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err, irqPin, breakIrq, wakeIrq;
	logic        shortStopRecovery, watchdogDisable, lowPowerReq, lowPowerStop, breakReturn, systemReset;
	logic        forceSwiVector, breakState, flagClearAllow, clearIntMask, stackStart;
	logic        cpuClockEn, busClockEn, refClockEn, watchdogRun;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [7:0]  vecHi, vecLo;
	logic [6:0]  ev;
	logic [1:0]  cmd;
	logic [4:0]  powerState;
	int          n_mismatch, comparisons, n;
	blr_top dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.porEvent(ev[0]), .pinReset_n(!ev[1]), .watchdogTimeout(ev[2]), .badOpcode(ev[3]),
		.badAddress(ev[4]), .monitorCheck(ev[5]), .lowVoltage(ev[6]), .resetVectorHi(vecHi),
		.resetVectorLo(vecLo), .irqPin, .systemReset, .breakIrq, .breakReturn, .forceSwiVector,
		.breakState, .flagClearAllow, .lowPowerReq, .lowPowerStop, .wakeIrq, .shortStopRecovery,
		.watchdogDisable, .clearIntMask, .stackStart, .cpuClockEn, .busClockEn, .refClockEn,
		.watchdogRun, .powerState);
	blr_cpu_model cpu (.clk, .arst_n, .cmd, .lowPowerReq, .lowPowerStop, .breakReturn);
	// Clock of 100 ns period.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Compares one value and keeps the tallies.
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	// One APB transfer; data and error are taken at the completing edge.
	task apb(input logic w, input logic [17:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Reads a register and compares it.
	task rd(input logic [17:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(rdat, {24'h0, e});
	endtask
	// Pulses one reset cause for a cycle and lets it settle.
	task ping(input int k);
		@(posedge clk);
		ev <= 7'h01 << k;
		@(posedge clk);
		ev <= 7'h00;
		repeat (4) @(posedge clk);
	endtask
	// Asks the CPU model for one request.
	task go(input logic [1:0] c);
		@(posedge clk);
		cmd <= c;
		@(posedge clk);
		cmd <= 2'h0;
	endtask
	// Counts edges until the chosen output is high: 0 mask clear, 1 stack start, 2 forced vector.
	task waitfor(input int w);
		n = 0;
		while ((w == 0 ? clearIntMask : w == 1 ? stackStart : forceSwiVector) !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task t_regs;
		rd(RS, 8'h80);
		rd(RS, 8'h00);
		rd(BS, 8'h00);
		rd(BF, 8'h00);
		apb(1'b0, 18'h3_F808, 8'h00);
		chk(err, 1'b1);
		for (int k = 0; k < 7; k++) begin
			ping(k);
			rd(RS, 8'h80 >> k);
		end
		vecLo <= 8'hFE;
		ping(5);
		rd(RS, 8'h00);
		ping(2);
		ping(0);
		rd(RS, 8'h80);
		$display("register test done");
	endtask
	task t_wait;
		ping(2);
		go(2'h1);
		waitfor(0);
		chk({cpuClockEn, busClockEn, refClockEn, watchdogRun, powerState}, 9'h0E2);
		wakeIrq <= 1'b1;
		@(posedge clk);
		wakeIrq <= 1'b0;
		waitfor(1);
		chk(n, 2);
		go(2'h1);
		waitfor(0);
		breakIrq <= 1'b1;
		waitfor(2);
		chk({breakState, flagClearAllow, powerState}, 7'h41);
		breakIrq <= 1'b0;
		rd(BS, 8'h02);
		rd(RS, 8'h20);
		rd(RS, 8'h20);
		apb(1'b1, BS, 8'h00);
		rd(BS, 8'h00);
		apb(1'b1, BF, 8'h80);
		rd(RS, 8'h20);
		go(2'h3);
		rd(RS, 8'h00);
		chk(breakState, 1'b0);
		apb(1'b1, BF, 8'h00);
		$display("wait and break test done");
	endtask
	task automatic t_stop(input logic s, input int lo);
		shortStopRecovery <= s;
		go(2'h2);
		waitfor(0);
		chk({cpuClockEn, busClockEn, refClockEn, watchdogRun, powerState}, 9'h004);
		wakeIrq <= 1'b1;
		@(posedge clk);
		wakeIrq <= 1'b0;
		waitfor(1);
		chk(n >= lo && n <= lo + 4, 1'b1);
		$display("stop test done");
	endtask
	// Reset sources end wait and stop; a mid-run reset restores the register defaults.
	task t_exits;
		watchdogDisable <= 1'b1;
		go(2'h1);
		waitfor(0);
		chk(n, 2);
		chk({watchdogRun, cpuClockEn, powerState}, 7'h02);
		@(posedge clk);
		ev <= 7'h44;
		@(posedge clk);
		ev <= 7'h00;
		@(posedge clk);
		chk({systemReset, powerState}, 6'h21);
		repeat (3) @(posedge clk);
		rd(RS, 8'h22);
		rd(BS, 8'h00);
		go(2'h2);
		waitfor(0);
		ping(3);
		chk(powerState, 5'h01);
		rd(RS, 8'h10);
		watchdogDisable <= 1'b0;
		apb(1'b1, BF, 8'h80);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rd(RS, 8'h80);
		rd(BF, 8'h00);
		$display("exit and reset test done");
	endtask
	// Prints the counts and the verdict, then ends the run.
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Main sequence after a five-cycle reset.
	initial begin
		arst_n = 1'b0;
		{psel, penable, pwrite, breakIrq, wakeIrq, watchdogDisable, paddr, pwdata, ev, cmd} = '0;
		{shortStopRecovery, irqPin, vecHi, vecLo} = 18'h3_FFFF;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		t_regs;
		t_wait;
		t_stop(1'b1, 32);
		t_stop(1'b1, 32);
		t_exits;
		t_stop(1'b0, 4096);
		wrap_up;
	end
	// Cuts a hang short well after the expected run length.
	initial begin
		#3_000_000;
		n_mismatch++;
		wrap_up;
	end
endmodule
bind blr_top blr_top_asserts chk_i (.clk, .arst_n, .psel, .paddr, .pslverr, .breakIrq, .breakState,
	.forceSwiVector, .lowPowerReq, .systemReset, .wakeIrq, .shortStopRecovery, .clearIntMask,
	.stackStart, .cpuClockEn, .busClockEn, .refClockEn, .powerState);
